/* design/tbg_regs.svh */
/*
 * register map, bit positions and divider counts of the timer and baud block.
 * assumes a plain 4-bit register port with 8-bit data; included by bare name.
 */
`ifndef TBG_REGS_SVH
`define TBG_REGS_SVH

// register indices on the register port
`define TBG_A_TCTRL    4'h0
`define TBG_A_TMODE    4'h1
`define TBG_A_T0LO     4'h2
`define TBG_A_T0HI     4'h3
`define TBG_A_T1LO     4'h4
`define TBG_A_T1HI     4'h5
`define TBG_A_PWR      4'h6
`define TBG_A_SCTRL    4'h7
`define TBG_A_SDATA    4'h8
`define TBG_A_T2CTRL   4'h9
`define TBG_A_T2RLO    4'hA
`define TBG_A_T2RHI    4'hB
`define TBG_A_T2CLO    4'hC
`define TBG_A_T2CHI    4'hD

// timer control register bits
`define TBG_B_T1_FLAG  7
`define TBG_B_T1_RUN   6
`define TBG_B_T0_FLAG  5
`define TBG_B_T0_RUN   4

// timer mode register: timer 1 in the upper nibble, timer 0 in the lower
`define TBG_B_T1_GATE  7
`define TBG_B_T1_CNT   6
`define TBG_F_T1_MODE  5:4
`define TBG_B_T0_GATE  3
`define TBG_B_T0_CNT   2
`define TBG_F_T0_MODE  1:0

// power, serial and timer 2 control bits
`define TBG_B_BAUD_DBL 7
`define TBG_F_SMODE    7:6
`define TBG_B_REN      4
`define TBG_B_RX_DONE  0
`define TBG_B_RCLK     5
`define TBG_B_TX_CLOCK_SELECT     4
`define TBG_B_T2_RUN   2

// divider end counts and constants
`define TBG_DIV12_LAST 4'hB
`define TBG_DIV32_LAST 5'h1F
`define TBG_DIV16_LAST 5'h0F
`define TBG_BYTE_ONES  8'hFF
`define TBG_WORD_ONES  16'hFFFF
`define TBG_BYTE_ZERO  8'h00
`define TBG_PIN_IDLE   1'b1

`endif

/* design/tbg_pkg.sv */
/*
 * types of the timer and baud block: timer modes and serial modes.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package tbg_pkg;
   // timer operating modes, in field order
   typedef enum logic [1:0] {TBG_T_13BIT, TBG_T_16BIT, TBG_T_RELOAD8, TBG_T_SPLIT} tbg_tmode_t;
   // serial port modes, in field order
   typedef enum logic [1:0] {TBG_S_SHIFT, TBG_S_UART8, TBG_S_UART9F, TBG_S_UART9V} tbg_smode_t;
endpackage

/* design/tbg_timer01_baud.sv */
/*
 * timers 0 and 1 with four modes, timer 2 baud generator and serial bit-rate ticks.
 * assumes a core register port on clk_i, pins from outside the clock domain,
 * and a serial port that consumes the bit ticks and start pulses.
 */
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tbg_regs.svh"
module tbg_timer01_baud
   import tbg_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // register port
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wr_data_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output var  logic [7:0] rd_data_o,
   // external pins
   input  wire logic       t0_count_pin_i,
   input  wire logic       t1_count_pin_i,
   input  wire logic       external_interrupt0_pin_i,
   input  wire logic       external_interrupt1_pin_i,
   input  wire logic       serial_rx_pin_i,
   // serial port logic
   input  wire logic       rx_done_i,
   output var  logic       timer0_overflow_flag_o,
   output var  logic       timer1_overflow_flag_o,
   output var  logic       tx_bit_tick_o,
   output var  logic       rx_bit_tick_o,
   output var  logic       tx_start_o,
   output var  logic       rx_start_o,
   output var  logic [7:0] tx_data_o
);

   // pin synchronisers: index 0 t0, 1 t1, 2 external_interrupt0_pin, 3 int1, 4 rx
   logic [4:0] pins;
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic [4:0] sync3;
   logic [4:0] pin_level;
   logic [4:0] pin_prev;
   logic [4:0] pin_fall;

   assign pins = {serial_rx_pin_i, external_interrupt1_pin_i, external_interrupt0_pin_i,
                  t1_count_pin_i, t0_count_pin_i};

   // three flops per pin; a level is taken once the second and third agree
   generate
      for (genvar i = 0; i < 5; i++) begin : g_sync
         logic next_s1;
         logic next_s2;
         logic next_s3;
         logic next_lvl;
         always_comb begin
            next_s1  = pins[i];
            next_s2  = sync1[i];
            next_s3  = sync2[i];
            next_lvl = (sync2[i] == sync3[i]) ? sync3[i] : pin_level[i];
         end
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               sync1[i]     <= `TBG_PIN_IDLE;
               sync2[i]     <= `TBG_PIN_IDLE;
               sync3[i]     <= `TBG_PIN_IDLE;
               pin_level[i] <= `TBG_PIN_IDLE;
               pin_prev[i]  <= `TBG_PIN_IDLE;
            end else begin
               sync1[i]     <= next_s1;
               sync2[i]     <= next_s2;
               sync3[i]     <= next_s3;
               pin_level[i] <= next_lvl;
               pin_prev[i]  <= pin_level[i];
            end
         end
         assign pin_fall[i] = pin_prev[i] & ~pin_level[i];
      end
   endgenerate

   // one count step: returns {overflow, high, low}
   function automatic logic [16:0] tbg_step(input tbg_tmode_t md, input logic [7:0] lo, input logic [7:0] hi);
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0]  c8;
      c13 = {1'b0, hi, lo[4:0]} + 14'h1;
      c16 = {1'b0, hi, lo} + 17'h1;
      c8  = {1'b0, lo} + 9'h1;
      case (md)
         TBG_T_13BIT:   tbg_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]}; // upper low bits left alone
         TBG_T_16BIT:   tbg_step = c16;
         TBG_T_RELOAD8: tbg_step = {c8[8], hi, c8[8] ? hi : c8[7:0]};       // reload, high kept
         default:       tbg_step = {c8[8], hi, c8[7:0]};
      endcase
   endfunction

   // software state and timers 0 and 1
   logic [7:0]  tmode;
   logic        tr0, tr1, tf0, tf1;
   logic [7:0]  tl0, th0, tl1, th1;
   logic        baud_dbl, ren, rx_flag, rclk, tx_clock_select, tr2;
   logic [1:0]  smode_bits;
   logic [7:0]  rcap_lo, rcap_hi;
   logic [7:0]  next_tmode, next_tl0, next_th0, next_tl1, next_th1, next_rcap_lo, next_rcap_hi, next_tx_data;
   logic        next_tr0, next_tr1, next_tf0, next_tf1;
   logic        next_baud_dbl, next_ren, next_rx_flag, next_rclk, next_tx_clock_select, next_tr2, next_tx_start;
   logic [1:0]  next_smode_bits;
   tbg_tmode_t  t0_mode, t1_mode;
   tbg_smode_t  smode;
   logic        t0_tick, t1_tick, t0hi_tick, t0_ovf, t1_ovf, split;
   logic [16:0] st0, st1;
   logic [8:0]  th0_inc;

   assign t0_mode = tbg_tmode_t'(tmode[`TBG_F_T0_MODE]);
   assign t1_mode = tbg_tmode_t'(tmode[`TBG_F_T1_MODE]);
   assign smode   = tbg_smode_t'(smode_bits);
   assign split   = (t0_mode == TBG_T_SPLIT);

   always_comb begin
      // gating and count source; no prescaler in front
      t0_tick   = tr0 && (!tmode[`TBG_B_T0_GATE] || pin_level[2])
                  && (tmode[`TBG_B_T0_CNT] ? pin_fall[0] : 1'b1);
      t1_tick   = tr1 && (!tmode[`TBG_B_T1_GATE] || pin_level[3])
                  && (tmode[`TBG_B_T1_CNT] ? pin_fall[1] : 1'b1)
                  && (t1_mode != TBG_T_SPLIT);                         // mode 3 holds timer 1
      t0hi_tick = split && tr1;                                        // split high byte counts cycles
      st0       = tbg_step(t0_mode, tl0, th0);
      st1       = tbg_step(t1_mode, tl1, th1);
      th0_inc   = {1'b0, th0} + 9'h1;
      t0_ovf    = t0_tick && st0[16];
      t1_ovf    = t1_tick && st1[16];
      next_tmode = tmode;
      next_tr0 = tr0;
      next_tr1 = tr1;
      next_tl0 = tl0;
      next_th0 = th0;
      next_tl1 = tl1;
      next_th1 = th1;
      next_baud_dbl = baud_dbl;
      next_smode_bits = smode_bits;
      next_ren = ren;
      next_rclk = rclk;
      next_tx_clock_select = tx_clock_select;
      next_tr2 = tr2;
      next_rcap_lo = rcap_lo;
      next_rcap_hi = rcap_hi;
      next_tx_data = tx_data_o;
      next_tx_start = 1'b0;
      next_tf0 = tf0;
      next_tf1 = tf1;
      next_rx_flag = rx_flag;
      // counting works from the present contents
      if (t0_tick) begin
         next_tl0 = st0[7:0];
         next_th0 = st0[15:8];
      end
      if (t0hi_tick) begin
         next_th0 = th0_inc[7:0];
      end
      if (t1_tick) begin
         next_tl1 = st1[7:0];
         next_th1 = st1[15:8];
      end
      // software writes override the count of the same cycle
      if (wr_i) begin
         case (addr_i)
            `TBG_A_TCTRL: begin
               next_tr0 = wr_data_i[`TBG_B_T0_RUN];
               next_tr1 = wr_data_i[`TBG_B_T1_RUN];
               next_tf0 = wr_data_i[`TBG_B_T0_FLAG];
               next_tf1 = wr_data_i[`TBG_B_T1_FLAG];
            end
            `TBG_A_TMODE:  next_tmode = wr_data_i;
            `TBG_A_T0LO:   next_tl0 = wr_data_i;
            `TBG_A_T0HI:   next_th0 = wr_data_i;
            `TBG_A_T1LO:   next_tl1 = wr_data_i;
            `TBG_A_T1HI:   next_th1 = wr_data_i;
            `TBG_A_PWR:    next_baud_dbl = wr_data_i[`TBG_B_BAUD_DBL];
            `TBG_A_SCTRL: begin
               next_smode_bits = wr_data_i[`TBG_F_SMODE];
               next_ren = wr_data_i[`TBG_B_REN];
               next_rx_flag = wr_data_i[`TBG_B_RX_DONE];
            end
            `TBG_A_SDATA: begin
               next_tx_data = wr_data_i;
               next_tx_start = 1'b1;                                   // any buffer write starts sending
            end
            `TBG_A_T2CTRL: begin
               next_rclk = wr_data_i[`TBG_B_RCLK];
               next_tx_clock_select = wr_data_i[`TBG_B_TX_CLOCK_SELECT];
               next_tr2 = wr_data_i[`TBG_B_T2_RUN];
            end
            `TBG_A_T2RLO:  next_rcap_lo = wr_data_i;
            `TBG_A_T2RHI:  next_rcap_hi = wr_data_i;
            default:       next_tmode = tmode;
         endcase
      end
      // hardware set wins over a software clear
      if (t0_ovf) begin
         next_tf0 = 1'b1;
      end
      if (split ? (t0hi_tick && th0_inc[8]) : t1_ovf) begin
         next_tf1 = 1'b1;
      end
      if (rx_done_i) begin
         next_rx_flag = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tmode <= `TBG_BYTE_ZERO;
         tr0 <= 1'b0;
         tr1 <= 1'b0;
         tf0 <= 1'b0;
         tf1 <= 1'b0;
         tl0 <= `TBG_BYTE_ZERO;
         th0 <= `TBG_BYTE_ZERO;
         tl1 <= `TBG_BYTE_ZERO;
         th1 <= `TBG_BYTE_ZERO;
         baud_dbl <= 1'b0;
         smode_bits <= 2'h0;
         ren <= 1'b0;
         rx_flag <= 1'b0;
         rclk <= 1'b0;
         tx_clock_select <= 1'b0;
         tr2 <= 1'b0;
         rcap_lo <= `TBG_BYTE_ZERO;
         rcap_hi <= `TBG_BYTE_ZERO;
         tx_data_o <= `TBG_BYTE_ZERO;
         tx_start_o <= 1'b0;
      end else begin
         tmode <= next_tmode;
         tr0 <= next_tr0;
         tr1 <= next_tr1;
         tf0 <= next_tf0;
         tf1 <= next_tf1;
         tl0 <= next_tl0;
         th0 <= next_th0;
         tl1 <= next_tl1;
         th1 <= next_th1;
         baud_dbl <= next_baud_dbl;
         smode_bits <= next_smode_bits;
         ren <= next_ren;
         rx_flag <= next_rx_flag;
         rclk <= next_rclk;
         tx_clock_select <= next_tx_clock_select;
         tr2 <= next_tr2;
         rcap_lo <= next_rcap_lo;
         rcap_hi <= next_rcap_hi;
         tx_data_o <= next_tx_data;
         tx_start_o <= next_tx_start;
      end
   end

   assign timer0_overflow_flag_o = tf0;
   assign timer1_overflow_flag_o = tf1;

   // timer 2 baud generator and the twelve-cycle shift divider
   logic [15:0] t2_cnt, next_t2_cnt;
   logic        t2_half, next_t2_half, t2_inc, t2_ovf;
   logic [3:0]  div12, next_div12;
   logic        tick12;

   always_comb begin
      next_t2_half = t2_half;
      t2_inc = 1'b0;
      if (tr2 && (rclk || tx_clock_select)) begin
         next_t2_half = !t2_half;
         t2_inc = t2_half;                                             // one step per two clocks
      end
      t2_ovf = t2_inc && (t2_cnt == `TBG_WORD_ONES);
      next_t2_cnt = t2_cnt;
      if (t2_ovf) begin
         next_t2_cnt = {rcap_hi, rcap_lo};                             // reload gives 65536 minus reload
      end else if (t2_inc) begin
         next_t2_cnt = t2_cnt + 16'h1;
      end
      tick12 = (div12 == `TBG_DIV12_LAST);
      next_div12 = tick12 ? 4'h0 : div12 + 4'h1;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         t2_cnt <= 16'h0000;
         t2_half <= 1'b0;
         div12 <= 4'h0;
      end else begin
         t2_cnt <= next_t2_cnt;
         t2_half <= next_t2_half;
         div12 <= next_div12;
      end
   end

   // bit-rate dividers: index 0 transmit, 1 receive
   logic [1:0] bit_tick;
   generate
      for (genvar d = 0; d < 2; d++) begin : g_baud
         logic [4:0] cnt, next_cnt;
         logic       src, next_tick, use_t2;
         logic [4:0] last;
         always_comb begin
            use_t2 = (d == 0) ? tx_clock_select : rclk;
            case (smode)
               TBG_S_SHIFT: begin
                  src = tick12;
                  last = 5'h00;
               end
               TBG_S_UART9F: begin
                  src = 1'b1;
                  last = baud_dbl ? `TBG_DIV16_LAST : `TBG_DIV32_LAST;
               end
               default: begin                                          // variable rate modes
                  src = use_t2 ? t2_ovf : t1_ovf;
                  last = (use_t2 || baud_dbl) ? `TBG_DIV16_LAST : `TBG_DIV32_LAST;
               end
            endcase
            next_cnt = cnt;
            next_tick = 1'b0;
            if (src) begin
               next_tick = (cnt >= last);
               next_cnt = (cnt >= last) ? 5'h00 : cnt + 5'h01;
            end
         end
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               cnt <= 5'h00;
               bit_tick[d] <= 1'b0;
            end else begin
               cnt <= next_cnt;
               bit_tick[d] <= next_tick;
            end
         end
      end
   endgenerate

   assign tx_bit_tick_o = bit_tick[0];
   assign rx_bit_tick_o = bit_tick[1];

   // receive start and register reads
   logic       rx_cond, next_rx_cond, next_rx_start;
   logic [7:0] next_rd_data;

   always_comb begin
      next_rx_cond = !rx_flag && ren;
      if (smode == TBG_S_SHIFT) begin
         next_rx_start = next_rx_cond && !rx_cond;
      end else begin
         next_rx_start = ren && pin_fall[4];                           // start bit
      end
      next_rd_data = `TBG_BYTE_ZERO;
      if (rd_i) begin
         case (addr_i)
            `TBG_A_TCTRL:  next_rd_data = {tf1, tr1, tf0, tr0, 4'h0};
            `TBG_A_TMODE:  next_rd_data = tmode;
            `TBG_A_T0LO:   next_rd_data = tl0;
            `TBG_A_T0HI:   next_rd_data = th0;
            `TBG_A_T1LO:   next_rd_data = tl1;
            `TBG_A_T1HI:   next_rd_data = th1;
            `TBG_A_PWR:    next_rd_data = {baud_dbl, 7'h00};
            `TBG_A_SCTRL:  next_rd_data = {smode_bits, 1'b0, ren, 3'h0, rx_flag};
            `TBG_A_SDATA:  next_rd_data = tx_data_o;
            `TBG_A_T2CTRL: next_rd_data = {2'h0, rclk, tx_clock_select, 1'b0, tr2, 2'h0};
            `TBG_A_T2RLO:  next_rd_data = rcap_lo;
            `TBG_A_T2RHI:  next_rd_data = rcap_hi;
            `TBG_A_T2CLO:  next_rd_data = t2_cnt[7:0];
            `TBG_A_T2CHI:  next_rd_data = t2_cnt[15:8];
            default:       next_rd_data = `TBG_BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_cond <= 1'b0;
         rx_start_o <= 1'b0;
         rd_data_o <= `TBG_BYTE_ZERO;
      end else begin
         rx_cond <= next_rx_cond;
         rx_start_o <= next_rx_start;
         rd_data_o <= next_rd_data;
      end
   end

   // checks
   property p_t0_flag_set;
      @(posedge clk_i) disable iff (!rst_n_i) t0_ovf |=> timer0_overflow_flag_o;
   endproperty
   a_t0_flag_set: assert property (p_t0_flag_set) else $error("timer 0 overflow lost");

   property p_t0_gate;
      @(posedge clk_i) disable iff (!rst_n_i)
         (!tr0 && !t0hi_tick && !wr_i) |=> $stable(tl0);
   endproperty
   a_t0_gate: assert property (p_t0_gate) else $error("timer 0 counted while stopped");

   property p_t1_split_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
         (t1_mode == TBG_T_SPLIT && !wr_i) |=> ($stable(tl1) && $stable(th1));
   endproperty
   a_t1_split_hold: assert property (p_t1_split_hold) else $error("timer 1 moved in mode 3");

   property p_t0_reload;
      @(posedge clk_i) disable iff (!rst_n_i)
         (t0_tick && t0_mode == TBG_T_RELOAD8 && tl0 == `TBG_BYTE_ONES && !wr_i)
         |=> (tl0 == $past(th0) && th0 == $past(th0));
   endproperty
   a_t0_reload: assert property (p_t0_reload) else $error("mode 2 reload wrong");

   property p_t0_mode0_upper;
      @(posedge clk_i) disable iff (!rst_n_i)
         (t0_mode == TBG_T_13BIT && !wr_i) |=> (tl0[7:5] == $past(tl0[7:5]));
   endproperty
   a_t0_mode0_upper: assert property (p_t0_mode0_upper) else $error("mode 0 touched upper bits");

   property p_tx_start;
      @(posedge clk_i) disable iff (!rst_n_i)
         (wr_i && addr_i == `TBG_A_SDATA) |=> (tx_start_o && tx_data_o == $past(wr_data_i));
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("buffer write did not start");

   property p_shift_rate;
      @(posedge clk_i) disable iff (!rst_n_i)
         (tx_bit_tick_o && smode == TBG_S_SHIFT && $past(smode) == TBG_S_SHIFT)
         |-> ##12 (tx_bit_tick_o || smode != TBG_S_SHIFT);
   endproperty
   a_shift_rate: assert property (p_shift_rate) else $error("mode 0 rate not twelve");

   property p_t2_half;
      @(posedge clk_i) disable iff (!rst_n_i) (t2_inc && !t2_ovf) |=> !t2_inc ##1 $stable(t2_cnt);
   endproperty
   a_t2_half: assert property (p_t2_half) else $error("timer 2 stepped too fast");

   property p_rx_mode0;
      @(posedge clk_i) disable iff (!rst_n_i)
         rx_start_o |-> $past(ren);
   endproperty
   a_rx_mode0: assert property (p_rx_mode0) else $error("receive start without enable");

endmodule
`default_nettype wire

/* tb/tbg_far_side.sv */
/*
 * far side serial port model: meters bit tick spacing and ends a frame
 * eight receive ticks after each receive start. assumes the block's clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tbg_far_side (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // ticks and start from the block
   input  wire logic        tx_bit_tick_i,
   input  wire logic        rx_bit_tick_i,
   input  wire logic        rx_start_i,
   // frame end and measured spacing
   output logic        rx_done_o,
   output logic [15:0] tx_period_o,
   output logic [15:0] rx_period_o
);
   logic [15:0] tx_cnt;
   logic [15:0] rx_cnt;
   logic [3:0]  bits_left;
   // tick spacing and frame end; no timer 1 interrupt is ever used here
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_cnt <= 16'h0001;
         rx_cnt <= 16'h0001;
         tx_period_o <= 16'h0000;
         rx_period_o <= 16'h0000;
         bits_left <= 4'h0;
         rx_done_o <= 1'b0;
      end else begin
         tx_cnt <= tx_bit_tick_i ? 16'h0001 : tx_cnt + 16'h0001;
         rx_cnt <= rx_bit_tick_i ? 16'h0001 : rx_cnt + 16'h0001;
         if (tx_bit_tick_i) tx_period_o <= tx_cnt;
         if (rx_bit_tick_i) rx_period_o <= rx_cnt;
         rx_done_o <= 1'b0;
         if (rx_start_i) bits_left <= 4'h8;
         else if (rx_bit_tick_i && bits_left != 4'h0) begin
            bits_left <= bits_left - 4'h1;
            rx_done_o <= (bits_left == 4'h1);
         end
      end
   end
endmodule
`default_nettype wire

/* tb/timer01_and_baud_generation_tb.sv */
/*
 * self-checking bench of the timer and baud block: reads and transmit
 * bytes are checked against queued notes. assumes design and far side model.
 */
`timescale 1ns/1ps
`default_nettype none
module timer01_and_baud_generation_tb;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [3:0]  addr_i = 4'h0;
   logic [7:0]  wr_data_i = 8'h00;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        rd_d = 1'b0;
   logic        cnt_pin = 1'b1;
   logic        gate_pin = 1'b0;
   logic        rx_pin = 1'b1;
   logic        rx_done, tx_tick, rx_tick, tx_start, rx_start, fl0, fl1;
   logic [7:0]  rd_data_o, tx_data, h;
   logic [15:0] tx_per, rx_per;
   logic [7:0]  rq[$];
   logic [7:0]  tq[$];
   int          seed = 68407;
   int          err_count = 0;
   int          num_checks = 0;
   int          rx_starts = 0;
   int          cyc = 0;
   // serial ctrl, power, expected tx and rx tick spacing
   logic [7:0]  cfg[5][4] = '{'{8'h00, 8'h00, 8'h0C, 8'h0C}, '{8'h80, 8'h00, 8'h20, 8'h20},
      '{8'h80, 8'h80, 8'h10, 8'h10}, '{8'h40, 8'h00, 8'h80, 8'h80}, '{8'hC0, 8'h80, 8'h40, 8'h40}};

   tbg_timer01_baud i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .t0_count_pin_i(cnt_pin), .t1_count_pin_i(cnt_pin),
      .external_interrupt0_pin_i(gate_pin), .external_interrupt1_pin_i(gate_pin), .serial_rx_pin_i(rx_pin),
      .rx_done_i(rx_done), .timer0_overflow_flag_o(fl0), .timer1_overflow_flag_o(fl1),
      .tx_bit_tick_o(tx_tick), .rx_bit_tick_o(rx_tick), .tx_start_o(tx_start), .rx_start_o(rx_start),
      .tx_data_o(tx_data));
   tbg_far_side i_far (.clk_i(clk_i), .rst_n_i(rst_n_i), .tx_bit_tick_i(tx_tick), .rx_bit_tick_i(rx_tick),
      .rx_start_i(rx_start), .rx_done_o(rx_done), .tx_period_o(tx_per), .rx_period_o(rx_per));

   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks = num_checks + 1;
      if (g !== e) begin
         err_count = err_count + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      rd_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      rq.push_back(e);
      addr_i <= a;
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge clk_i);
   endtask
   task automatic idle(input int n);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      repeat (n) @(posedge clk_i);
   endtask
   // run for n counts, reading control before the stop
   task automatic run(input logic [7:0] c, input int n, input logic [7:0] e);
      wr(4'h0, c);
      idle(n - 2);
      rd(4'h0, e);
      chk({14'h0000, fl1, fl0}, {14'h0000, e[7], e[5]});
      wr(4'h0, 8'h00);
   endtask
   task end_sim;
      if (err_count == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // compare reads and transmit bytes with the oldest notes; cut hangs short
   always @(posedge clk_i) begin
      rd_d <= rd_i;
      cyc <= cyc + 1;
      if (rd_d) chk(rd_data_o, rq.pop_front());
      if (tx_start) chk(tx_data, tq.pop_front());
      if (rx_start) rx_starts <= rx_starts + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         end_sim();
      end
   end

   // main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      wr(4'hE, 8'hFF);
      wr(4'hC, 8'h55);
      rd(4'hE, 8'h00);
      rd(4'hC, 8'h00);
      rd(4'h3, 8'h00);
      wr(4'h1, 8'h01);
      wr(4'h2, 8'hFD);
      wr(4'h3, 8'hFF);
      run(8'h10, 6, 8'h30);
      rd(4'h2, 8'h03);
      rd(4'h3, 8'h00);
      wr(4'h1, 8'h00);
      wr(4'h2, 8'h1E);
      wr(4'h3, 8'hFF);
      run(8'h10, 6, 8'h30);
      rd(4'h2, 8'h04);
      rd(4'h3, 8'h00);
      h = {1'b0, $random(seed) & 7'h7F};
      wr(4'h1, 8'h02);
      wr(4'h3, h);
      wr(4'h2, 8'hFE);
      run(8'h10, 6, 8'h30);
      rd(4'h2, h + 8'h04);
      rd(4'h3, h);
      wr(4'h1, 8'h09);
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h00);
      run(8'h10, 6, 8'h10);
      rd(4'h2, 8'h00);
      gate_pin <= 1'b1;
      idle(6);
      run(8'h10, 6, 8'h10);
      run(8'h10, 6, 8'h10);
      rd(4'h2, 8'h0C);
      wr(4'h1, 8'h33);
      wr(4'h2, 8'h00);
      wr(4'h3, 8'hFD);
      wr(4'h4, 8'h00);
      wr(4'h5, 8'h00);
      run(8'h40, 6, 8'hC0);
      rd(4'h3, 8'h03);
      rd(4'h2, 8'h00);
      rd(4'h4, 8'h00);
      wr(4'h1, 8'h13);
      run(8'h40, 6, 8'h40);
      rd(4'h4, 8'h06);
      wr(4'h1, 8'h50);
      wr(4'h4, 8'h00);
      wr(4'h0, 8'h40);
      repeat (3) begin
         cnt_pin <= 1'b0;
         idle(6);
         cnt_pin <= 1'b1;
         idle(6);
      end
      wr(4'h0, 8'h00);
      rd(4'h4, 8'h03);
      wr(4'h9, 8'h14);
      idle(19);
      wr(4'h9, 8'h00);
      rd(4'hC, 8'h0A);
      wr(4'h1, 8'h20);
      wr(4'h5, 8'hFC);
      wr(4'h0, 8'h40);
      for (int i = 0; i < 5; i++) begin
         wr(4'h7, cfg[i][0]);
         wr(4'h6, cfg[i][1]);
         h = $random(seed);
         tq.push_back(h);
         wr(4'h8, h);
         idle(4 * cfg[i][2]);
         chk(tx_per, {8'h00, cfg[i][2]});
         chk(rx_per, {8'h00, cfg[i][3]});
      end
      wr(4'h7, 8'h50);
      rx_pin <= 1'b0;
      idle(8);
      rx_pin <= 1'b1;
      wr(4'h7, 8'h00);
      wr(4'h7, 8'h10);
      idle(150);
      rd(4'h7, 8'h11);
      wr(4'h7, 8'h10);
      idle(6);
      chk(rx_starts, 3);
      chk(tq.size(), 0);
      end_sim();
   end
endmodule
`default_nettype wire
